// ### shared/gbs_pkg.sv
// Shared constants and types for the gain and band select latches
package gbs_pkg;

  // Bus and latch widths
  localparam int unsigned GBS_ADDR_W    = 4;
  localparam int unsigned GBS_DATA_W    = 8;
  localparam int unsigned GBS_BW_W      = 7;
  localparam int unsigned GBS_GAIN_W    = 3;
  localparam int unsigned GBS_BAND_W    = 4;
  localparam int unsigned GBS_NUM_BANDS = 11;

  // Field positions within the written data byte
  localparam int unsigned GBS_GAIN_LSB  = 0;
  localparam int unsigned GBS_BAND_LSB  = 3;
  localparam int unsigned GBS_SEL_BIT   = 7;

  // Gain step bit positions inside the gain code
  localparam int unsigned GBS_STEP10A   = 0;
  localparam int unsigned GBS_STEP20    = 1;
  localparam int unsigned GBS_STEP10B   = 2;

  // Extra-gain eligible band range
  localparam int unsigned GBS_XG_FIRST  = 4;
  localparam int unsigned GBS_XG_LAST   = 10;

  // Reset value of both latches, and the bus address of the latches
  localparam logic [GBS_DATA_W-1:0] GBS_LATCH_RST = 8'h00;
  localparam logic [GBS_ADDR_W-1:0] GBS_VR_ADDR   = 4'h0;

  // Value of the supplemental address bit for each latch
  localparam logic GBS_SEL_BW   = 1'b0;
  localparam logic GBS_SEL_GAIN = 1'b1;

  // Write target chosen by the decoder
  typedef enum logic [1:0] {
    GBS_TGT_NONE = 2'b00,
    GBS_TGT_BW   = 2'b01,
    GBS_TGT_GAIN = 2'b11
  } gbs_tgt_t;

endpackage : gbs_pkg

// ### shared/gbs_band_if.sv
// Carries the held band number to the band decoder and its outputs back
interface gbs_band_if;
  import gbs_pkg::*;
  logic [GBS_BAND_W-1:0]    band_num;
  logic [GBS_NUM_BANDS-1:0] band_sel_n;
  modport latch (output band_num, input band_sel_n);
  modport dec   (input band_num, output band_sel_n);
endinterface : gbs_band_if

// ### rtl/gbs_band_dec.sv
// One-of-N active-low band decoder
module gbs_band_dec (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Band number in, decoded band lines out
  gbs_band_if.dec   bus
);
  import gbs_pkg::*;

  logic [GBS_NUM_BANDS-1:0] sel_d;
  logic [GBS_NUM_BANDS-1:0] sel_q;

  // Band k drives line k-1 low; band 0 and unused codes select nothing
  always_comb begin
    sel_d = '1;
    for (int k = 1; k <= GBS_NUM_BANDS; k++) begin
      if (bus.band_num == GBS_BAND_W'(k)) begin
        sel_d[k-1] = 1'b0;
      end
    end
  end

  // Registered so the outputs never glitch between writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sel_q <= '1;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign bus.band_sel_n = sel_q;

endmodule : gbs_band_dec

// ### rtl/gbs_latches.sv
// Gain step and band select latches for the variable-resolution IF stages
//
// Overview of operation
// - Address plus valid, bit 7 picks latch
// - Latches load only when their address decodes
// - Bandwidth latch drives both filter selectors
// - Bits 0-2 gain, 3-6 band, held
// - High held gain bit gives low enable
// - All three step enables high: base gain
// - Enables add 20 dB and 10 dB
// - Band n asserts active-low output n-1
// - Bands 4-10 may feed extra-gain line
// - Bit 0 drives first 10 dB step
module gbs_latches #(
  parameter int unsigned ADDR_W  = gbs_pkg::GBS_ADDR_W,
  parameter logic [gbs_pkg::GBS_ADDR_W-1:0] VR_ADDR = gbs_pkg::GBS_VR_ADDR
) (
  // Clock and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_b,
  // Parallel bus from the master microcomputer
  input  wire logic [ADDR_W-1:0]                    bus_addr,
  input  wire logic [gbs_pkg::GBS_DATA_W-1:0]       bus_data,
  input  wire logic                                 bus_valid,
  // Per-band extra-gain enables set at calibration
  input  wire logic [gbs_pkg::GBS_NUM_BANDS-1:0]    xg_band_en,
  // Filter selection
  output logic [gbs_pkg::GBS_BW_W-1:0]              bw_sel,
  // Active-low gain step enables
  output logic                                      step10a_n,
  output logic                                      step20_n,
  output logic                                      step10b_n,
  // Band outputs
  output logic [gbs_pkg::GBS_NUM_BANDS-1:0]         band_level_drive,
  output logic                                      band_extra_gain_n
);
  import gbs_pkg::*;

  // The decode and the port widths must agree
  if (ADDR_W != GBS_ADDR_W) begin : g_bad_addr_w
    $error("ADDR_W must equal the package address width");
  end

  // Bus pins arrive from another domain: two-stage synchronisers
  logic [ADDR_W-1:0]     addr_s1_q, addr_s2_q;
  logic [GBS_DATA_W-1:0] data_s1_q, data_s2_q;
  logic                  valid_s1_q, valid_s2_q, valid_s3_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      addr_s1_q  <= '0;
      addr_s2_q  <= '0;
      data_s1_q  <= '0;
      data_s2_q  <= '0;
      valid_s1_q <= 1'b0;
      valid_s2_q <= 1'b0;
      valid_s3_q <= 1'b0;
    end else begin
      addr_s1_q  <= bus_addr;
      addr_s2_q  <= addr_s1_q;
      data_s1_q  <= bus_data;
      data_s2_q  <= data_s1_q;
      valid_s1_q <= bus_valid;
      valid_s2_q <= valid_s1_q;
      valid_s3_q <= valid_s2_q;
    end
  end

  // One write per valid strobe: act on its rising edge only, so a long
  // strobe is not taken twice; address and data settle with the strobe
  logic     wr_stb;
  gbs_tgt_t tgt;

  assign wr_stb = valid_s2_q & ~valid_s3_q;

  always_comb begin
    tgt = GBS_TGT_NONE;
    if (wr_stb && addr_s2_q == VR_ADDR) begin
      if (data_s2_q[GBS_SEL_BIT] == GBS_SEL_GAIN) begin
        tgt = GBS_TGT_GAIN;
      end else begin
        tgt = GBS_TGT_BW;
      end
    end
  end

  // Latch state
  logic [GBS_BW_W-1:0]   bw_d, bw_q;
  logic [GBS_GAIN_W-1:0] gain_d, gain_q;
  logic [GBS_BAND_W-1:0] band_d, band_q;

  always_comb begin
    bw_d   = bw_q;
    gain_d = gain_q;
    band_d = band_q;
    case (tgt)
      GBS_TGT_BW: begin
        bw_d = data_s2_q[GBS_BW_W-1:0];
      end
      GBS_TGT_GAIN: begin
        gain_d = data_s2_q[GBS_GAIN_LSB +: GBS_GAIN_W];
        band_d = data_s2_q[GBS_BAND_LSB +: GBS_BAND_W];
      end
      default: begin
        bw_d = bw_q;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bw_q   <= GBS_LATCH_RST[GBS_BW_W-1:0];
      gain_q <= GBS_LATCH_RST[GBS_GAIN_W-1:0];
      band_q <= GBS_LATCH_RST[GBS_BAND_W-1:0];
    end else begin
      bw_q   <= bw_d;
      gain_q <= gain_d;
      band_q <= band_d;
    end
  end

  assign bw_sel = bw_q;

  // Active-low step enables, registered so they change only after a write
  logic [GBS_GAIN_W-1:0] step_n_d, step_n_q;

  assign step_n_d = ~gain_d;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      step_n_q <= '1;
    end else begin
      step_n_q <= step_n_d;
    end
  end

  assign step10a_n = step_n_q[GBS_STEP10A];
  // 20 dB and 10 dB steps
  assign step20_n  = step_n_q[GBS_STEP20];
  assign step10b_n = step_n_q[GBS_STEP10B];

  // Band decoder instance
  gbs_band_if band_bus ();

  assign band_bus.band_num = band_q;

  gbs_band_dec u_band_dec (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .bus     (band_bus.dec)
  );

  assign band_level_drive = band_bus.band_sel_n;

  // Calibration enables are pins too: two flops before any logic; left
  // out of reset so they keep tracking the pins through a reset
  logic [GBS_NUM_BANDS-1:0] xg_s1_q, xg_s2_q;

  always_ff @(posedge clk_sys) begin
    xg_s1_q <= xg_band_en;
    xg_s2_q <= xg_s1_q;
  end

  // Wired-OR of the low from eligible bands, gated by calibration enables
  logic [GBS_NUM_BANDS-1:0] xg_term;
  logic                     xg_n_d, xg_n_q;

  for (genvar b = 0; b < GBS_NUM_BANDS; b++) begin : g_xg
    if (b + 1 >= GBS_XG_FIRST && b + 1 <= GBS_XG_LAST) begin : g_on
      assign xg_term[b] = xg_s2_q[b] & ~band_bus.band_sel_n[b];
    end else begin : g_off
      assign xg_term[b] = 1'b0;
    end
  end

  assign xg_n_d = ~(|xg_term);

  // Registered so the shared line never glitches; one cycle behind bands
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      xg_n_q <= 1'b1;
    end else begin
      xg_n_q <= xg_n_d;
    end
  end

  assign band_extra_gain_n = xg_n_q;

endmodule : gbs_latches

// ### tb/gbs_latches_props.sv
// Port-level assertions for the gain and band select latches
module gbs_latches_props #(
  parameter int unsigned ADDR_W  = 4,
  parameter logic [3:0]  VR_ADDR = 4'h0
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_b,
  // Bus and calibration inputs
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [7:0]        bus_data,
  input wire logic              bus_valid,
  input wire logic [10:0]       xg_band_en,
  // Latch outputs
  input wire logic [6:0]        bw_sel,
  input wire logic              step10a_n,
  input wire logic              step20_n,
  input wire logic              step10b_n,
  input wire logic [10:0]       band_level_drive,
  input wire logic              band_extra_gain_n
);
  // Bus pins pass two sync flops, so causes sit 2 or 3 edges back
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_bw_cause: assert property (
    $changed(bw_sel) |-> $past(bus_valid, 2) && !$past(bus_data[7], 2)
    && $past(bus_addr, 2) == VR_ADDR) else $error("bw_sel moved unasked");
  a_bw_value: assert property (
    $changed(bw_sel) |-> bw_sel == $past(bus_data[6:0], 2))
    else $error("bw_sel wrong");
  a_gain_cause: assert property (
    $changed({step10b_n, step20_n, step10a_n, band_level_drive})
    |-> $past(bus_valid, 3) && $past(bus_data[7], 3)
    && $past(bus_addr, 3) == VR_ADDR) else $error("gain moved unasked");
  a_step_value: assert property (
    $changed({step10b_n, step20_n, step10a_n})
    |-> {step10b_n, step20_n, step10a_n} == ~$past(bus_data[2:0], 3))
    else $error("step enables wrong");
  a_band_value: assert property (
    $changed(band_level_drive) |-> band_level_drive
    == ~(11'h001 << ($past(bus_data[6:3], 3) - 1)))
    else $error("band lines wrong");
  a_band_one_low: assert property (
    $countones(~band_level_drive) <= 1) else $error("two band lines low");
  // Line is registered one edge after the bands; enables pass two syncs
  a_xg_line: assert property (
    band_extra_gain_n == !(|(~$past(band_level_drive)
    & $past(xg_band_en, 3) & 11'h3F8))) else $error("extra gain wrong");
  a_reset_clear: assert property (disable iff (1'b0)
    !rst_b [*2] |-> bw_sel == 7'h00 && step10a_n && step20_n && step10b_n
    && &band_level_drive && band_extra_gain_n) else $error("reset");
endmodule : gbs_latches_props

bind gbs_latches gbs_latches_props #(
  .ADDR_W(ADDR_W),
  .VR_ADDR(VR_ADDR)
) i_props (.*);

// ### tb/gbs_mcu_model.sv
// Bus master model that writes bytes to the latches
module gbs_mcu_model (
  // Clock
  input  wire logic clk_sys,
  // Parallel bus
  output logic [3:0] bus_addr,
  output logic [7:0] bus_data,
  output logic       bus_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    bus_addr  = 4'hF;
    bus_data  = 8'h00;
    bus_valid = 1'b0;
  end
  // Address and data settle one edge before the strobe rises, so the
  // synchronised strobe never meets a half-changed byte; strobe holds
  // four edges, drops for one, then the bus is released and idles three
  task automatic write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    bus_addr  = a;
    bus_data  = d;
    @(posedge clk_sys);
    #1;
    bus_valid = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    bus_valid = 1'b0;
    @(posedge clk_sys);
    // Released lines show the inverse, never the stale byte
    #1;
    bus_addr = ~a;
    bus_data = ~d;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : write
endmodule : gbs_mcu_model

// ### tb/gain_band_select_latches_test.sv
// Self-checking bench for the gain and band select latches
module gain_band_select_latches_test;
  timeunit 1ns;
  timeprecision 100ps;
  import gbs_pkg::*;
  typedef logic [21:0] gbs_obs_t;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  bus_addr;
  logic [7:0]  bus_data;
  logic        bus_valid;
  logic [10:0] xg_band_en = 11'h000;
  logic [6:0]  bw_sel;
  logic        step10a_n, step20_n, step10b_n, band_extra_gain_n;
  logic [10:0] band_level_drive;
  logic [6:0]  bw_m = 7'h00;
  logic [7:0]  gb_m = 8'h00;
  gbs_obs_t    exp_q[$];
  int          miscompares = 0;
  int          checked = 0;
  event        settled;
  initial forever #2 clk_sys = ~clk_sys;
  gbs_latches i_dut (.*);
  gbs_mcu_model i_mst (.*);
  // Outputs that the modelled latch contents should give
  function automatic gbs_obs_t expect_now();
    logic [10:0] lines;
    lines = ~(11'h001 << (gb_m[6:3] - 1));
    return {bw_m, ~gb_m[2:0], lines, ~|(~lines & xg_band_en & 11'h3F8)};
  endfunction : expect_now
  // Write a byte, update the model and note the result
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    if (a == GBS_VR_ADDR && d[7])
      gb_m = d;
    else if (a == GBS_VR_ADDR)
      bw_m = d[6:0];
    i_mst.write(a, d);
    exp_q.push_back(expect_now());
    -> settled;
  endtask : put
  // Oldest note against the settled outputs
  initial forever begin
    gbs_obs_t seen, want;
    @(settled);
    seen = {bw_sel, step10b_n, step20_n, step10a_n, band_level_drive,
            band_extra_gain_n};
    want = exp_q.pop_front();
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] outputs expected %h seen %h", want, seen);
    end
  end
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // Watchdog well past the roughly 600 cycles needed
  initial begin
    #8000;
    miscompares++;
    test_done();
  end
  initial begin
    void'($urandom(75));
    repeat (20) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    @(posedge clk_sys);
    #1;
    exp_q.push_back(expect_now());
    -> settled;
    for (int i = 0; i < 16; i++)
      put(GBS_VR_ADDR, {1'b1, i[3:0], i[2:0]});
    for (int i = 0; i < 40; i++) begin
      xg_band_en = 11'($urandom);
      put(($urandom % 3 == 0) ? 4'($urandom) : GBS_VR_ADDR,
          8'($urandom));
    end
    // Mid-run reset must clear whatever the random writes left behind
    rst_b = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    bw_m = 7'h00;
    gb_m = 8'h00;
    @(posedge clk_sys);
    #1;
    exp_q.push_back(expect_now());
    -> settled;
    // First write after the second reset still lands
    put(GBS_VR_ADDR, 8'h55);
    test_done();
  end
endmodule : gain_band_select_latches_test
